// file: rtl/intc_pkg.sv
// Package: constants, register map and carriers of the interrupt acceptance unit
package intc_pkg;
  localparam int NSRC = 8;
  localparam int VW   = 3;
  localparam int PW   = 4;

  localparam logic [11:0] PENDING_OFF   = 12'h000;
  localparam logic [11:0] PEND_CLR_OFF  = 12'h004;
  localparam logic [11:0] SRC_EN_OFF    = 12'h008;
  localparam logic [11:0] ACT_EN_OFF    = 12'h00C;
  localparam logic [11:0] PRIO_OFF      = 12'h010;
  localparam logic [11:0] NMI_EN_OFF    = 12'h014;
  localparam logic [11:0] SWTRIG_OFF    = 12'h018;
  localparam logic [11:0] PSW_OFF       = 12'h01C;
  localparam logic [11:0] XCTRL_OFF     = 12'h020;
  localparam logic [11:0] ACK_OFF       = 12'h024;
  localparam logic [11:0] EVT_STAT_OFF  = 12'h028;
  localparam logic [11:0] EVT_MASK_OFF  = 12'h02C;
  localparam logic [11:0] PRESENT_OFF   = 12'h030;

  localparam int PSW_EN_BIT   = 0;
  localparam int PSW_IPL_LSB  = 4;
  localparam int XCTRL_RS_BIT = 0;
  localparam int ACK_VEC_LSB  = 0;
  localparam int ACK_GO_BIT   = 8;
  localparam int PRES_VAL_BIT = 8;
  localparam int EV_CPU  = 0;
  localparam int EV_NMI  = 1;
  localparam int EV_DONE = 2;
  localparam int EVW     = 3;

  localparam logic [PW-1:0] IPL_RESET = 4'h0;
  localparam logic [31:0]   WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0]    HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic          valid;
    logic [VW-1:0] vec;
  } src_sel_t;

  typedef struct packed {
    logic          start;
    logic          last;
    logic          done;
    logic [VW-1:0] vec;
  } xfer_evt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } xfer_state_t;
endpackage

// file: rtl/prio_pick.sv
// Priority arbiter picking the highest accepted request
`timescale 1ns/1ps
module prio_pick
  import intc_pkg::*;
(
  // Requests and their levels
  input  wire logic [NSRC-1:0]    req,
  input  wire logic [NSRC*PW-1:0] level,
  // Winner
  output src_sel_t                pick,
  output logic [PW-1:0]           pick_level
);
  // Strict greater-than keeps the lowest vector on a tie
  always_comb begin
    pick       = '{valid: 1'b0, vec: '0};
    pick_level = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (!pick.valid || level[i*PW +: PW] > pick_level)) begin
        pick.valid = 1'b1;
        pick.vec   = VW'(i);
        pick_level = level[i*PW +: PW];
      end
    end
  end
endmodule

// file: rtl/intc_accept.sv
// Interrupt acceptance and transfer-controller activation unit
//
// Overview of operation
// - Per-vector activation enable sends a set source to transfer unit
// - Software trigger raises a request that can activate the transfer unit
// - Activation enables and trigger register sit here, not in transfer unit
// - After the final transfer, CPU sees the activating source's own request
// - Forward needs global enable, source enable/level, peripheral enable
// - Accept only levels strictly above the four-bit threshold
// - Reset: global enable 0, threshold 0000b
// - Threshold 0 and enable 1 accepts any nonzero level
// - All request flags (peripheral, non-maskable) held here
// - Source enable bits for maskable, separate register for non-maskable
// - Per-source software priority used for acceptance and arbitration
// - Writing 0 to read-skip control resets the read-skip flag
// - Peripheral request enable gates each request before it pends
// - Non-final transfer start clears the pending flag, no CPU interrupt
// - Final transfer end clears activation enable, presents request
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module intc_accept
  import intc_pkg::*;
(
  // Clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // AHB-Lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic [31:0]          hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // Request sources
  input  wire logic [NSRC-1:0] periph_req,
  input  wire logic [NSRC-1:0] periph_req_en,
  input  wire logic            nmi_req,
  // Transfer unit side
  input  xfer_evt_t            xfer_evt,
  output logic                 xfer_act_r,
  output logic [VW-1:0]        xfer_vec_r,
  output logic                 readskip_flag_r,
  // Processor side
  output logic                 cpu_irq_r,
  output logic [VW-1:0]        cpu_vec_r,
  output logic                 cpu_nmi_r,
  output logic                 irq_r
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [NSRC-1:0]    pend_r, pend_nxt;
  logic [NSRC-1:0]    src_en_r, src_en_nxt;
  logic [NSRC-1:0]    act_en_r, act_en_nxt;
  logic [NSRC*PW-1:0] prio_r, prio_nxt;
  logic               nmi_en_r, nmi_en_nxt;
  logic               nmi_pend_r, nmi_pend_nxt;
  logic               psw_en_r, psw_en_nxt;
  logic [PW-1:0]      ipl_r, ipl_nxt;
  logic               rs_ctl_r, rs_ctl_nxt;
  logic               rsf_nxt;
  logic [EVW-1:0]     ev_stat_r, ev_stat_nxt;
  logic [EVW-1:0]     ev_mask_r, ev_mask_nxt;
  xfer_state_t        st_r, st_nxt;
  logic               act_nxt;
  logic [VW-1:0]      xvec_nxt;
  logic               cirq_nxt, cnmi_nxt, irq_nxt;
  logic [VW-1:0]      cvec_nxt;

  // Bus address phase capture
  logic               wr_ph_r, wr_ph_nxt;
  logic               rd_ph_r, rd_ph_nxt;
  logic [11:0]        addr_r, addr_nxt;
  logic [31:0]        rdata_nxt;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [NSRC-1:0] cpu_cand, dtc_cand;
  src_sel_t        cpu_pick, dtc_pick;
  logic [PW-1:0]   cpu_lvl;

  function automatic logic [PW-1:0] lvl_of(input logic [NSRC*PW-1:0] p,
                                           input int                 i);
    lvl_of = p[i*PW +: PW];
  endfunction

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      // Zero level means disabled through the priority setting
      cpu_cand[i] = pend_r[i] && !act_en_r[i] && src_en_r[i] &&
                    (lvl_of(prio_r, i) != IPL_RESET) && psw_en_r &&
                    (lvl_of(prio_r, i) > ipl_r);
      dtc_cand[i] = pend_r[i] && act_en_r[i];
    end
  end

  prio_pick u_cpu_pick (
    .req        (cpu_cand),
    .level      (prio_r),
    .pick       (cpu_pick),
    .pick_level (cpu_lvl)
  );

  prio_pick u_dtc_pick (
    .req        (dtc_cand),
    .level      (prio_r),
    .pick       (dtc_pick),
    .pick_level ()
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        wr_go;
  logic [31:0] wdat;
  logic        ack_go;
  logic [VW-1:0] ack_vec;

  assign wr_go   = wr_ph_r;
  assign wdat    = hwdata;
  assign ack_go  = wr_go && (addr_r == ACK_OFF) && wdat[ACK_GO_BIT];
  assign ack_vec = wdat[ACK_VEC_LSB +: VW];

  function automatic logic [31:0] zext(input logic [NSRC-1:0] v);
    zext = {{(32-NSRC){1'b0}}, v};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    pend_nxt     = pend_r;
    src_en_nxt   = src_en_r;
    act_en_nxt   = act_en_r;
    prio_nxt     = prio_r;
    nmi_en_nxt   = nmi_en_r;
    nmi_pend_nxt = nmi_pend_r;
    psw_en_nxt   = psw_en_r;
    ipl_nxt      = ipl_r;
    rs_ctl_nxt   = rs_ctl_r;
    rsf_nxt      = readskip_flag_r;
    ev_mask_nxt  = ev_mask_r;
    ev_stat_nxt  = ev_stat_r;
    st_nxt       = st_r;
    act_nxt      = xfer_act_r;
    xvec_nxt     = xfer_vec_r;
    wr_ph_nxt    = 1'b0;
    rd_ph_nxt    = 1'b0;
    addr_nxt     = addr_r;
    rdata_nxt    = WORD_ZERO;

    // Software clears and writes first, hardware sets afterwards win
    if (wr_go) begin
      if (addr_r == PEND_CLR_OFF) begin
        pend_nxt = pend_r & ~wdat[NSRC-1:0];
      end else if (addr_r == SRC_EN_OFF) begin
        src_en_nxt = wdat[NSRC-1:0];
      end else if (addr_r == ACT_EN_OFF) begin
        act_en_nxt = wdat[NSRC-1:0];
      end else if (addr_r == PRIO_OFF) begin
        prio_nxt = wdat[NSRC*PW-1:0];
      end else if (addr_r == NMI_EN_OFF) begin
        nmi_en_nxt = wdat[0];
      end else if (addr_r == SWTRIG_OFF) begin
        pend_nxt = pend_r | wdat[NSRC-1:0];
      end else if (addr_r == PSW_OFF) begin
        psw_en_nxt = wdat[PSW_EN_BIT];
        ipl_nxt    = wdat[PSW_IPL_LSB +: PW];
      end else if (addr_r == XCTRL_OFF) begin
        rs_ctl_nxt = wdat[XCTRL_RS_BIT];
        if (!wdat[XCTRL_RS_BIT]) begin
          rsf_nxt = 1'b0;
        end
      end else if (addr_r == EVT_STAT_OFF) begin
        ev_stat_nxt = ev_stat_r & ~wdat[EVW-1:0];
      end else if (addr_r == EVT_MASK_OFF) begin
        ev_mask_nxt = wdat[EVW-1:0];
      end
    end

    // CPU acknowledge of an accepted request clears its flag
    if (ack_go) begin
      pend_nxt[ack_vec] = 1'b0;
    end

    // Transfer unit sequencing
    case (st_r)
      ST_IDLE: begin
        if (dtc_pick.valid) begin
          act_nxt  = 1'b1;
          xvec_nxt = dtc_pick.vec;
          st_nxt   = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (xfer_evt.start && !xfer_evt.last) begin
          pend_nxt[xfer_vec_r] = 1'b0;
        end
        if (xfer_evt.done) begin
          act_nxt = 1'b0;
          st_nxt  = ST_IDLE;
          if (xfer_evt.last) begin
            act_en_nxt[xfer_vec_r] = 1'b0;
            ev_stat_nxt[EV_DONE]   = 1'b1;
          end
          if (rs_ctl_r) begin
            rsf_nxt = 1'b1;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase

    // Gated peripheral requests set flags; set wins over clear
    pend_nxt = pend_nxt | (periph_req & periph_req_en);
    if (nmi_req && nmi_en_r) begin
      nmi_pend_nxt = 1'b1;
    end else if (wr_go && addr_r == PEND_CLR_OFF && wdat[NSRC]) begin
      nmi_pend_nxt = 1'b0;
    end
    if (cpu_pick.valid) begin
      ev_stat_nxt[EV_CPU] = 1'b1;
    end
    if (nmi_pend_r) begin
      ev_stat_nxt[EV_NMI] = 1'b1;
    end

    // Address phase
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      wr_ph_nxt = hwrite;
      rd_ph_nxt = !hwrite;
      addr_nxt  = haddr[11:0];
      if (!hwrite) begin
        if (haddr[11:0] == PENDING_OFF) begin
          rdata_nxt = {{(31-NSRC){1'b0}}, nmi_pend_r, pend_r};
        end else if (haddr[11:0] == SRC_EN_OFF) begin
          rdata_nxt = zext(src_en_r);
        end else if (haddr[11:0] == ACT_EN_OFF) begin
          rdata_nxt = zext(act_en_r);
        end else if (haddr[11:0] == PRIO_OFF) begin
          rdata_nxt = prio_r;
        end else if (haddr[11:0] == NMI_EN_OFF) begin
          rdata_nxt = {31'h0, nmi_en_r};
        end else if (haddr[11:0] == PSW_OFF) begin
          rdata_nxt = {24'h0, ipl_r, 3'h0, psw_en_r};
        end else if (haddr[11:0] == XCTRL_OFF) begin
          rdata_nxt = {30'h0, readskip_flag_r, rs_ctl_r};
        end else if (haddr[11:0] == EVT_STAT_OFF) begin
          rdata_nxt = {29'h0, ev_stat_r};
        end else if (haddr[11:0] == EVT_MASK_OFF) begin
          rdata_nxt = {29'h0, ev_mask_r};
        end else if (haddr[11:0] == PRESENT_OFF) begin
          rdata_nxt = {23'h0, cpu_pick.valid, 5'h0, cpu_pick.vec};
        end
      end
    end

    cirq_nxt = cpu_pick.valid;
    cvec_nxt = cpu_pick.vec;
    cnmi_nxt = nmi_pend_r;
    irq_nxt  = |(ev_stat_r & ev_mask_r);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r          <= '0;
      src_en_r        <= '0;
      act_en_r        <= '0;
      prio_r          <= '0;
      nmi_en_r        <= 1'b0;
      nmi_pend_r      <= 1'b0;
      psw_en_r        <= 1'b0;
      ipl_r           <= IPL_RESET;
      rs_ctl_r        <= 1'b0;
      readskip_flag_r <= 1'b0;
      ev_stat_r       <= '0;
      ev_mask_r       <= '0;
      st_r            <= ST_IDLE;
      xfer_act_r      <= 1'b0;
      xfer_vec_r      <= '0;
      cpu_irq_r       <= 1'b0;
      cpu_vec_r       <= '0;
      cpu_nmi_r       <= 1'b0;
      irq_r           <= 1'b0;
      wr_ph_r         <= 1'b0;
      rd_ph_r         <= 1'b0;
      addr_r          <= '0;
      hrdata          <= WORD_ZERO;
    end else begin
      pend_r          <= pend_nxt;
      src_en_r        <= src_en_nxt;
      act_en_r        <= act_en_nxt;
      prio_r          <= prio_nxt;
      nmi_en_r        <= nmi_en_nxt;
      nmi_pend_r      <= nmi_pend_nxt;
      psw_en_r        <= psw_en_nxt;
      ipl_r           <= ipl_nxt;
      rs_ctl_r        <= rs_ctl_nxt;
      readskip_flag_r <= rsf_nxt;
      ev_stat_r       <= ev_stat_nxt;
      ev_mask_r       <= ev_mask_nxt;
      st_r            <= st_nxt;
      xfer_act_r      <= act_nxt;
      xfer_vec_r      <= xvec_nxt;
      cpu_irq_r       <= cirq_nxt;
      cpu_vec_r       <= cvec_nxt;
      cpu_nmi_r       <= cnmi_nxt;
      irq_r           <= irq_nxt;
      wr_ph_r         <= wr_ph_nxt;
      rd_ph_r         <= rd_ph_nxt;
      addr_r          <= addr_nxt;
      hrdata          <= rdata_nxt;
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// file: verif/intc_accept_props.sv
// Checker: port-level properties of the acceptance unit
`timescale 1ns/1ps
module intc_accept_props
  import intc_pkg::*;
(
  // Bus side
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hready,
  input wire logic [31:0]   hrdata,
  input wire logic          hreadyout,
  input wire logic          hresp,
  // Requests and answers
  input wire logic          nmi_req,
  input xfer_evt_t          xfer_evt,
  input wire logic          xfer_act_r,
  input wire logic [VW-1:0] xfer_vec_r,
  input wire logic          readskip_flag_r,
  input wire logic          cpu_irq_r,
  input wire logic [VW-1:0] cpu_vec_r,
  input wire logic          cpu_nmi_r
);
  logic rd_gap;
  logic wr_rs;
  logic take;
  assign take   = hsel && hready && htrans == HTRANS_NONSEQ;
  assign rd_gap = take && !hwrite && haddr[11:2] > 10'h00C;
  assign wr_rs  = take && hwrite && haddr[11:0] == XCTRL_OFF;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_GAP_ZERO: assert property (rd_gap |=> hrdata == WORD_ZERO)
    else $error("unmapped read gave nonzero data");
  AST_RST_QUIET: assert property ($rose(hresetn) |-> !cpu_irq_r [*3])
    else $error("request presented right after reset");
  AST_ACT_HOLD: assert property (xfer_act_r && !xfer_evt.done
    |=> xfer_act_r && $stable(xfer_vec_r))
    else $error("activation dropped or vector moved");
  AST_ACT_END: assert property (xfer_act_r && xfer_evt.done
    |=> !xfer_act_r)
    else $error("activation held after done");
  AST_NONFINAL: assert property (xfer_evt.start && !xfer_evt.last
    |-> ##1 !(cpu_irq_r && cpu_vec_r == xfer_vec_r) [*3])
    else $error("processor request on a non-final transfer");
  AST_RS_SET: assert property ($rose(readskip_flag_r)
    |-> $past(xfer_evt.done))
    else $error("read-skip flag set without done");
  AST_RS_CLR: assert property ($fell(readskip_flag_r)
    |-> $past(wr_rs, 2))
    else $error("read-skip flag cleared without a write");
  AST_NMI_CAUSE: assert property ($rose(cpu_nmi_r)
    |-> $past(nmi_req) || $past(nmi_req, 2) || $past(nmi_req, 3))
    else $error("non-maskable request without a cause");
endmodule

// file: verif/xfer_model.sv
// Partner: behavioural transfer unit answering activations
`timescale 1ns/1ps
module xfer_model
  import intc_pkg::*;
(
  // Clock, reset and choice of final transfer
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          last_sel,
  // Activation from the unit
  input wire logic          xfer_act_r,
  input wire logic [VW-1:0] xfer_vec_r,
  // Events back
  output xfer_evt_t         xfer_evt
);
  // One transfer per activation; a slow start exercises the holding
  initial begin
    xfer_evt = '0;
    forever begin
      @(posedge hclk);
      if (hresetn && xfer_act_r) begin
        repeat (2) @(posedge hclk);
        xfer_evt <= '{1'h1, last_sel, 1'h0, xfer_vec_r};
        @(posedge hclk);
        xfer_evt <= '{1'h0, last_sel, 1'h1, xfer_vec_r};
        @(posedge hclk);
        xfer_evt <= '{1'h0, 1'h0, 1'h0, ~xfer_vec_r};
        @(posedge hclk);
      end
    end
  end
endmodule

// file: verif/tb.sv
// Testbench: acceptance table, transfer, trigger, NMI and event tests
`timescale 1ns/1ps
module tb;
  import intc_pkg::*;
  typedef struct {
    logic [31:0] en, pr, processor_status_word;
    logic [7:0]  pe, rq;
    logic [8:0]  pd;
    logic        ei;
    logic [2:0]  ev;
  } row_t;
  // Bit 8 of pd set: pending not compared
  row_t rows[9] = '{
    '{32'h1, 32'h1, 32'h1, 8'h1, 8'h1, 9'h001, 1'h1, 3'h0},
    '{32'h1, 32'h1, 32'h0, 8'h1, 8'h1, 9'h001, 1'h0, 3'h0},
    '{32'h0, 32'h1, 32'h1, 8'h1, 8'h1, 9'h100, 1'h0, 3'h0},
    '{32'h1, 32'h1, 32'h1, 8'h0, 8'h1, 9'h000, 1'h0, 3'h0},
    '{32'h1, 32'h0, 32'h1, 8'h1, 8'h1, 9'h100, 1'h0, 3'h0},
    '{32'h1, 32'h1, 32'h11, 8'h1, 8'h1, 9'h001, 1'h0, 3'h0},
    '{32'h1, 32'h2, 32'h11, 8'h1, 8'h1, 9'h001, 1'h1, 3'h0},
    '{32'h6, 32'h530, 32'h1, 8'h6, 8'h6, 9'h006, 1'h1, 3'h2},
    '{32'h6, 32'h440, 32'h1, 8'h6, 8'h6, 9'h006, 1'h1, 3'h1}};
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  periph_req = 8'h0;
  logic [7:0]  periph_req_en = 8'h0;
  logic        nmi_req = 1'h0;
  logic        last_sel = 1'h0;
  xfer_evt_t   xfer_evt;
  logic        xfer_act_r, readskip_flag_r, cpu_irq_r, cpu_nmi_r, irq_r;
  logic [2:0]  xfer_vec_r, cpu_vec_r;
  logic [31:0] q;
  int          err_count = 0;
  int          samples_checked = 0;

  always #25 hclk = ~hclk;
  intc_accept i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .periph_req(periph_req), .periph_req_en(periph_req_en),
    .nmi_req(nmi_req), .xfer_evt(xfer_evt), .xfer_act_r(xfer_act_r),
    .xfer_vec_r(xfer_vec_r), .readskip_flag_r(readskip_flag_r),
    .cpu_irq_r(cpu_irq_r), .cpu_vec_r(cpu_vec_r), .cpu_nmi_r(cpu_nmi_r),
    .irq_r(irq_r)
  );
  xfer_model i_xfer (
    .hclk(hclk), .hresetn(hresetn), .last_sel(last_sel),
    .xfer_act_r(xfer_act_r), .xfer_vec_r(xfer_vec_r), .xfer_evt(xfer_evt)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge hclk);
  endtask
  // Address phase held until ready, then data phase until ready
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic pls(logic [7:0] r);
    periph_req <= r;
    cyc(1);
    periph_req <= 8'h0;
  endtask
  task automatic pn;
    nmi_req <= 1'h1;
    cyc(1);
    nmi_req <= 1'h0;
    cyc(3);
  endtask
  task automatic wt(logic v);
    int t;
    for (t = 0; t < 64 && xfer_act_r !== v; t++) @(posedge hclk);
    chk("xfer_act", v, xfer_act_r);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(50 * 40000);
    err_count++;
    stop_test();
  end

  initial begin
    cyc(10);
    hresetn <= 1'h1;
    cyc(1);
    chk("cpu_irq", 0, cpu_irq_r);
    bus(0, PSW_OFF, 0);
    chk("psw", 0, q);
    bus(1, 12'h040, 32'hFFFF_FFFF);
    bus(0, 12'h040, 0);
    chk("unmapped", 0, q);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1, SRC_EN_OFF, rows[i].en);
      bus(1, PRIO_OFF, rows[i].pr);
      bus(1, PSW_OFF, rows[i].processor_status_word);
      periph_req_en <= rows[i].pe;
      pls(rows[i].rq);
      cyc(3);
      chk("cpu_irq", rows[i].ei, cpu_irq_r);
      if (rows[i].ei) chk("cpu_vec", rows[i].ev, cpu_vec_r);
      bus(0, PENDING_OFF, 0);
      if (!rows[i].pd[8]) chk("pending", rows[i].pd, q);
      bus(1, PSW_OFF, 0);
      bus(1, PEND_CLR_OFF, 32'h1FF);
      cyc(2);
      $display("row %0d done", i);
    end
    bus(1, SRC_EN_OFF, 32'h8);
    bus(1, PRIO_OFF, 32'h1000);
    bus(1, PSW_OFF, 32'h1);
    bus(1, ACT_EN_OFF, 32'h8);
    bus(1, XCTRL_OFF, 32'h1);
    periph_req_en <= 8'hFF;
    pls(8'h8);
    wt(1);
    chk("xfer_vec", 3, xfer_vec_r);
    wt(0);
    cyc(3);
    chk("cpu_irq", 0, cpu_irq_r);
    bus(0, PENDING_OFF, 0);
    chk("pending", 0, q);
    last_sel <= 1'h1;
    pls(8'h8);
    wt(1);
    wt(0);
    cyc(3);
    chk("cpu_irq", 1, cpu_irq_r);
    chk("cpu_vec", 3, cpu_vec_r);
    chk("readskip", 1, readskip_flag_r);
    bus(0, ACT_EN_OFF, 0);
    chk("act_en", 0, q);
    bus(1, XCTRL_OFF, 0);
    cyc(1);
    chk("readskip", 0, readskip_flag_r);
    bus(1, PEND_CLR_OFF, 32'h8);
    $display("test transfer done");
    bus(1, ACT_EN_OFF, 32'h20);
    bus(1, SWTRIG_OFF, 32'h20);
    wt(1);
    chk("xfer_vec", 5, xfer_vec_r);
    wt(0);
    bus(1, PEND_CLR_OFF, 32'h20);
    $display("test trigger done");
    pn();
    chk("cpu_nmi", 0, cpu_nmi_r);
    bus(1, NMI_EN_OFF, 32'h1);
    pn();
    chk("cpu_nmi", 1, cpu_nmi_r);
    bus(0, PENDING_OFF, 0);
    chk("pend_nmi", 1, q[8]);
    $display("test nmi done");
    bus(1, EVT_MASK_OFF, 32'h7);
    cyc(2);
    chk("irq", 1, irq_r);
    bus(1, EVT_MASK_OFF, 32'h0);
    cyc(2);
    chk("irq", 0, irq_r);
    bus(1, EVT_MASK_OFF, 32'h4);
    bus(1, EVT_STAT_OFF, 32'h7);
    cyc(2);
    chk("irq", 0, irq_r);
    bus(0, EVT_STAT_OFF, 0);
    chk("evt_done", 0, q[EV_DONE]);
    $display("test events done");
    bus(1, SRC_EN_OFF, 32'h10);
    bus(1, PRIO_OFF, 32'h1_0000);
    pls(8'h10);
    cyc(3);
    bus(0, PRESENT_OFF, 0);
    chk("present", 32'h104, q);
    bus(1, ACK_OFF, 32'h104);
    cyc(2);
    chk("cpu_irq", 0, cpu_irq_r);
    bus(1, PEND_CLR_OFF, 32'h100);
    cyc(2);
    chk("cpu_nmi", 0, cpu_nmi_r);
    $display("test acknowledge done");
    stop_test();
  end
endmodule

bind intc_accept intc_accept_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .nmi_req(nmi_req),
  .xfer_evt(xfer_evt), .xfer_act_r(xfer_act_r), .xfer_vec_r(xfer_vec_r),
  .readskip_flag_r(readskip_flag_r), .cpu_irq_r(cpu_irq_r),
  .cpu_vec_r(cpu_vec_r), .cpu_nmi_r(cpu_nmi_r)
);
